// >>> pkg/ptb_pkg.sv
// Operation
// R1: 15-bit counter, prescaler, postscaler, readable count
// R2: Count bit 15 reads direction, 1 down
// R3: Enable starts/stops; disable keeps count
// R4: Period match resets or reverses next tick
// R5: Zero period stops counter, no events
// R6: Zero active period blocks reload until disabled
// R7: 2-bit mode: 00 free-run, 01 single-shot
// R8: Event depends on mode and postscale
// R9: Free-run returns to zero, keeps counting
// R10: Free-run event per match, postscaled
// R11: Single-shot match zeroes count, clears enable
// R12: Single-shot one event, postscaler ignored
// R13: Mode 10 up/down, event at zero
// R14: Mode 11 events at zero and match
// R15: Prescaler 1:1, 1:4, 1:16, 1:64
// R16: Count/control writes clear scaler counters
// R17: Step on prescale tick; postscale 1..16
// R18: Export count, direction; reset clears state
package ptb_pkg;
  localparam int CW = 15;
  localparam int AW = 3;
  localparam logic [AW-1:0] ADDR_CONTROL = 3'h0;
  localparam logic [AW-1:0] ADDR_COUNT   = 3'h1;
  localparam logic [AW-1:0] ADDR_PERIOD  = 3'h2;
  localparam logic [AW-1:0] ADDR_STATUS  = 3'h3;
  localparam logic [AW-1:0] ADDR_CLEAR   = 3'h4;
  localparam logic [AW-1:0] ADDR_IRQ_EN  = 3'h5;
  // Control layout
  localparam int BIT_ENABLE  = 15;
  localparam int OPS_LSB     = 4;
  localparam int CKPS_LSB    = 2;
  localparam int MOD_LSB     = 0;
  localparam int DIR_BIT     = 15;
  // Status bits
  localparam int ST_EVENT    = 0;
  localparam int ST_ZERO     = 1;
  localparam int ST_MATCH    = 2;
  localparam int NST         = 3;
  localparam logic [1:0] MODE_FREE   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_UPDN   = 2'h2;
  localparam logic [1:0] MODE_DOUBLE = 2'h3;
  localparam logic [CW-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CW-1:0] CNT_ONE  = 15'h0001;
  localparam logic [5:0] PRE_1  = 6'h00;
  localparam logic [5:0] PRE_4  = 6'h03;
  localparam logic [5:0] PRE_16 = 6'h0F;
  localparam logic [5:0] PRE_64 = 6'h3F;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
endpackage

// >>> hw/ptb_time_base.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ptb_time_base (
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   clk_en_in,
  input  wire logic [ptb_pkg::AW-1:0] addr_in,
  input  wire logic [15:0]            wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [15:0]            rdata_out,
  output logic      [ptb_pkg::CW-1:0] count_out,
  output logic                        count_direction_flag_out,
  output logic                        event_out,
  output logic                        irq_out
);
  import ptb_pkg::*;

  logic            timebase_enable_ff;
  logic [3:0]      postscale_select_ff;
  logic [1:0]      prescale_select_ff;
  logic [1:0]      timebase_mode_select_ff;
  logic [CW-1:0]   count_ff;
  logic            dir_ff;
  logic [CW-1:0]   period_buf_ff;
  logic [CW-1:0]   period_ff;
  logic [5:0]      pre_ff;
  logic [3:0]      post_ff;
  logic [NST-1:0]  status_ff;
  logic [NST-1:0]  irq_en_ff;
  logic [15:0]     rdata_ff;
  logic            event_ff;

  wire wr_ctl  = wr_in && addr_in == ADDR_CONTROL;
  wire wr_cnt  = wr_in && addr_in == ADDR_COUNT;
  wire wr_per  = wr_in && addr_in == ADDR_PERIOD;
  wire wr_clr  = wr_in && addr_in == ADDR_CLEAR;
  wire wr_ien  = wr_in && addr_in == ADDR_IRQ_EN;
  wire scaler_clr = wr_cnt || wr_ctl; // R16

  // R15
  wire [5:0] pre_limit = (prescale_select_ff == 2'h0) ? PRE_1 :
                         (prescale_select_ff == 2'h1) ? PRE_4 :
                         (prescale_select_ff == 2'h2) ? PRE_16 : PRE_64;
  wire pre_tick   = timebase_enable_ff && pre_ff == pre_limit;
  wire per_zero   = period_ff == CNT_ZERO;            // R5
  wire step       = pre_tick && !per_zero;            // R17
  wire at_match   = count_ff == period_ff;            // R4
  wire updown     = timebase_mode_select_ff[1];       // R13 R14
  wire match_step = step && at_match && !dir_ff;
  wire zero_step  = step && updown && dir_ff && count_ff == CNT_ONE;
  // Reload points: zero reached or reset after match; only if period nonzero R6
  wire reload_pt  = (!updown && match_step) || zero_step;
  wire post_src   = updown ? zero_step : match_step;
  wire post_done  = post_ff == postscale_select_ff;
  // R8 R10 R12 R13 R14
  wire fire = (timebase_mode_select_ff == MODE_SINGLE) ? match_step :
              (timebase_mode_select_ff == MODE_DOUBLE) ? (match_step || zero_step) :
              (post_src && post_done);

  wire [CW-1:0] count_up = count_ff + CNT_ONE;
  wire [CW-1:0] count_dn = count_ff - CNT_ONE;
  wire [NST-1:0] ev_vec  = {match_step, zero_step || (!updown && match_step), fire};
  wire [NST-1:0] clr_vec = wr_clr ? wdata_in[NST-1:0] : {NST{1'b0}};

  wire [15:0] rd_mux =
    (addr_in == ADDR_CONTROL) ? {timebase_enable_ff, 7'h00, postscale_select_ff,
                                 prescale_select_ff, timebase_mode_select_ff} :
    (addr_in == ADDR_COUNT)   ? {dir_ff, count_ff} :   // R1 R2
    (addr_in == ADDR_PERIOD)  ? {1'b0, period_buf_ff} :
    (addr_in == ADDR_STATUS)  ? {13'h0000, status_ff} :
    (addr_in == ADDR_IRQ_EN)  ? {13'h0000, irq_en_ff} : DATA_ZERO;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timebase_enable_ff      <= 1'b0; // R18
      postscale_select_ff     <= 4'h0;
      prescale_select_ff      <= 2'h0;
      timebase_mode_select_ff <= MODE_FREE;
      count_ff                <= CNT_ZERO;
      dir_ff                  <= 1'b0;
      period_buf_ff           <= CNT_ZERO;
      period_ff               <= CNT_ZERO;
      pre_ff                  <= 6'h00;
      post_ff                 <= 4'h0;
      status_ff               <= {NST{1'b0}};
      irq_en_ff               <= {NST{1'b0}};
      rdata_ff                <= DATA_ZERO;
      event_ff                <= 1'b0;
    end else if (clk_en_in) begin
      rdata_ff <= rd_in ? rd_mux : DATA_ZERO;
      event_ff <= fire;
      // Set wins over clear
      status_ff <= (status_ff & ~clr_vec) | ev_vec;
      if (wr_ien) begin
        irq_en_ff <= wdata_in[NST-1:0];
      end
      if (wr_per) begin
        period_buf_ff <= wdata_in[CW-1:0]; // R4
      end
      // R3 R11
      if (wr_ctl) begin
        timebase_enable_ff      <= wdata_in[BIT_ENABLE]; // R3
        postscale_select_ff     <= wdata_in[OPS_LSB +: 4];
        prescale_select_ff      <= wdata_in[CKPS_LSB +: 2];
        timebase_mode_select_ff <= wdata_in[MOD_LSB +: 2]; // R7
      end else if (match_step && timebase_mode_select_ff == MODE_SINGLE) begin
        timebase_enable_ff <= 1'b0; // R11
      end
      // Period double buffer; zero active period only reloads while disabled
      if (!timebase_enable_ff || (reload_pt && !per_zero)) begin
        period_ff <= period_buf_ff; // R6
      end
      // Prescaler
      if (scaler_clr || pre_tick) begin
        pre_ff <= 6'h00; // R16
      end else if (timebase_enable_ff) begin
        pre_ff <= pre_ff + 6'h01;
      end
      // Postscaler
      if (scaler_clr || (post_src && post_done)) begin
        post_ff <= 4'h0; // R16 R17
      end else if (post_src) begin
        post_ff <= post_ff + 4'h1;
      end
      // Counter
      if (wr_cnt) begin
        count_ff <= wdata_in[CW-1:0];
      end else if (step) begin
        if (match_step && !updown) begin
          count_ff <= CNT_ZERO; // R9 R11
        end else if (match_step) begin
          dir_ff   <= 1'b1; // R13
          count_ff <= count_dn;
        end else if (dir_ff) begin
          count_ff <= count_dn;
          if (count_ff == CNT_ONE) begin
            dir_ff <= 1'b0;
          end
        end else begin
          count_ff <= count_up; // R9
        end
      end
    end
  end

  assign rdata_out                = rdata_ff;
  assign count_out                = count_ff;  // R18
  assign count_direction_flag_out = dir_ff;
  assign event_out                = event_ff;
  assign irq_out                  = |(status_ff & irq_en_ff);
endmodule

// >>> test/ptb_time_base_monitor.sv
`timescale 1ns/1ps
module ptb_time_base_monitor
  import ptb_pkg::*;
(
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   clk_en_in,
  input wire logic [ptb_pkg::AW-1:0] addr_in,
  input wire logic [15:0]            wdata_in,
  input wire logic                   wr_in,
  input wire logic                   rd_in,
  input wire logic [15:0]            rdata_out,
  input wire logic [ptb_pkg::CW-1:0] count_out,
  input wire logic                   count_direction_flag_out,
  input wire logic                   event_out,
  input wire logic                   irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_count_read: assert property (rd_in && !wr_in && addr_in == ADDR_COUNT |=>
    rdata_out == {$past(count_direction_flag_out), $past(count_out)}) else $error("count read mismatch");
  a_count_load: assert property (wr_in && addr_in == ADDR_COUNT |=>
    count_out == $past(wdata_in[CW-1:0])) else $error("count write lost");
  a_single_step: assert property ($changed(count_out) && !$past(wr_in) |-> count_out == CNT_ZERO ||
    count_out == $past(count_out) + CNT_ONE || count_out == $past(count_out) - CNT_ONE) else $error("count jump");
  a_up_at_zero: assert property (count_out == CNT_ZERO |-> !count_direction_flag_out) else $error("down at zero");
  a_unmapped_zero: assert property (rd_in && addr_in > ADDR_IRQ_EN |=> rdata_out == DATA_ZERO) else $error("unmapped");
  a_irq_en_back: assert property (wr_in && addr_in == ADDR_IRQ_EN ##1 !wr_in ##1 rd_in && !wr_in && addr_in == ADDR_IRQ_EN |=>
    rdata_out[NST-1:0] == $past(wdata_in[NST-1:0], 3)) else $error("irq enable readback");
  a_reset_clear: assert property ($rose(rst_n_in) |-> count_out == CNT_ZERO && !count_direction_flag_out &&
    !irq_out) else $error("state after reset");
  a_event_pulse: assert property (event_out |=> !event_out) else $error("event wider than a cycle");
  c_event: cover property (event_out);
  c_down: cover property (count_direction_flag_out);
  c_irq: cover property (irq_out);
endmodule
bind ptb_time_base ptb_time_base_monitor mon_u (.clk_in, .rst_n_in, .clk_en_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .count_out, .count_direction_flag_out, .event_out, .irq_out);

// >>> test/ptb_time_base_tb.sv
`timescale 1ns/1ps
module ptb_time_base_tb;
  import ptb_pkg::*;
  logic          clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
  logic [AW-1:0] addr_in = '0;
  logic [15:0]   wdata_in = '0, d, d1;
  wire  [15:0]   rdata_out;
  wire  [CW-1:0] count_out;
  wire           count_direction_flag_out, event_out, irq_out;
  int            num_errors = 0, samples_checked = 0, cycles = 0, seed = 89, i;
  ptb_time_base dut_u (.clk_in, .rst_n_in, .clk_en_in(1'b1), .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .count_out, .count_direction_flag_out, .event_out, .irq_out);
  initial forever #2 clk_in = ~clk_in;
  task close_out;
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [AW-1:0] a, input logic [15:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [AW-1:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Sampled at the falling edge so the pulse has settled
  task wait_ev;
    i = 0;
    do begin
      @(negedge clk_in);
      i++;
    end while (event_out !== 1'b1 && i < 300);
  endtask
  function automatic logic [15:0] ctl(input logic en, input logic [1:0] m, input logic [7:0] sc);
    ctl = {8'h00, sc} << CKPS_LSB;
    ctl[BIT_ENABLE] = en;
    ctl[MOD_LSB +: 2] = m;
  endfunction
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(ADDR_COUNT);
    chk(d, DATA_ZERO);
    for (int k = 0; k < 4; k++) begin
      d1 = $random(seed);
      wr(ADDR_COUNT, d1);
      rd(ADDR_COUNT);
      chk(d, {1'b0, d1[CW-1:0]});
      rd(k[0] ? 3'h7 : 3'h6);
      chk(d, DATA_ZERO);
    end
    // Zero period: nothing may move
    wr(ADDR_PERIOD, DATA_ZERO);
    wr(ADDR_CONTROL, ctl(1'b1, MODE_FREE, 8'h00));
    repeat (30) @(posedge clk_in);
    rd(ADDR_COUNT);
    chk(d, {1'b0, d1[CW-1:0]});
    rd(ADDR_STATUS);
    chk(d, DATA_ZERO);
    wr(ADDR_CONTROL, DATA_ZERO);
    wr(ADDR_PERIOD, 16'h7FFF);
    wr(ADDR_COUNT, DATA_ZERO);
    wr(ADDR_CONTROL, ctl(1'b1, MODE_FREE, 8'h00));
    repeat (40) @(posedge clk_in);
    wr(ADDR_CONTROL, DATA_ZERO);
    rd(ADDR_COUNT);
    d1 = d;
    repeat (9) @(posedge clk_in);
    rd(ADDR_COUNT);
    chk(d, d1);
    chk({15'h0, d1 > 16'h0020}, 16'h0001);
    // Single shot with postscale 16, which must be ignored
    d1 = {12'h000, 4'($random(seed)) | 4'h1};
    wr(ADDR_PERIOD, d1);
    wr(ADDR_CLEAR, 16'h0007);
    wr(ADDR_IRQ_EN, 16'h0001);
    rd(ADDR_IRQ_EN);
    chk(d, 16'h0001);
    wr(ADDR_COUNT, DATA_ZERO);
    wr(ADDR_CONTROL, ctl(1'b1, MODE_SINGLE, 8'h3C));
    wait_ev;
    chk({15'h0, event_out}, 16'h0001);
    rd(ADDR_CONTROL);
    chk(d, ctl(1'b0, MODE_SINGLE, 8'h3C));
    rd(ADDR_COUNT);
    chk(d, DATA_ZERO);
    chk({15'h0, irq_out}, 16'h0001);
    wr(ADDR_CLEAR, 16'h0007);
    #1 chk({15'h0, irq_out}, DATA_ZERO);
    wr(ADDR_PERIOD, 16'h0003);
    wr(ADDR_CONTROL, ctl(1'b1, MODE_UPDN, 8'h01));
    wait_ev;
    chk({15'h0, event_out}, 16'h0001);
    chk({count_direction_flag_out, count_out}, DATA_ZERO);
    wr(ADDR_CONTROL, ctl(1'b1, MODE_DOUBLE, 8'h01));
    wait_ev;
    d1 = {1'b0, count_out};
    wait_ev;
    chk({15'h0, event_out && count_out != d1[CW-1:0]}, 16'h0001);
    close_out;
  end
endmodule
